// [hw/eest_pkg.sv]
// Contract
// [RULE1] With flash-card feature set on, command code 03h is the extended-error request.
// [RULE2] Extended-error request moves no data; completion shows only in status.
// [RULE3] Successful request places the 8-bit extended code in the error register.
// [RULE4] Normal request completion: busy clear, ready set, error flag clear.
// [RULE5] General codes: 00h none, 01h self test passed, 03h write/erase, 09h misc.
// [RULE6] ID and ECC codes: 10h, 14h ID not found, 11h uncorrectable, 18h corrected.
// [RULE7] Codes 1Fh transfer/abort, 20h invalid command, 21h address, 27h protect, 2Fh overflow.
// [RULE8] Voltage out of tolerance reports code 35h or 36h.
// [RULE9] Self test failures report 05h, 30h-34h, 37h or 3Eh; reserved codes never produced.
// [RULE10] Unsupported command sets the aborted bit in the error register.
// [RULE11] Error end: error flag set when any error bit set, busy clear, ready set.
// [RULE12] Error end: device fault flag set when an internal fault occurred.
// [RULE13] Host issues either command only while the ready flag reads one.
// [RULE14] Request must directly follow the failing command; device returns that cause.
// [RULE15] Code 87h is sector translate, run as PIO data-in through the data register.
// [RULE16] Without the feature set, 87h may be vendor specific instead.
// [RULE17] Translate address: sector index 7:0, cylinder low 15:8, cylinder high 23:16.
// [RULE18] Drive/head bit 6 selects linear (nibble is 27:24) or CYLINDER_HEAD_SECTOR_ADDRESSING (nibble is head).
// [RULE19] Successful translate delivers a 512-byte block describing the sector.
// [RULE20] Extended code of last failing command is kept until the next command begins.
package eest_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses.
    // ------------------------------------------------------------------
    localparam logic [5:0] ADDR_DATA    = 6'h00;
    localparam logic [5:0] ADDR_FEAT    = 6'h04;
    localparam logic [5:0] ADDR_SCNT    = 6'h08;
    localparam logic [5:0] ADDR_SIDX    = 6'h0c;
    localparam logic [5:0] ADDR_CYLL    = 6'h10;
    localparam logic [5:0] ADDR_CYLH    = 6'h14;
    localparam logic [5:0] ADDR_DRVH    = 6'h18;
    localparam logic [5:0] ADDR_CMD     = 6'h1c;
    localparam logic [5:0] ADDR_CTRL    = 6'h20;
    localparam logic [5:0] ADDR_XADDR   = 6'h24;
    localparam logic [5:0] ADDR_FAULT   = 6'h28;

    // ------------------------------------------------------------------
    // Command codes, fields and reset values.
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_EXT_ERR  = 8'h03;
    localparam logic [7:0] CMD_XLATE    = 8'h87;
    localparam int         BIT_BSY      = 7;
    localparam int         BIT_DEVICE_READY_FLAG     = 6;
    localparam int         BIT_DF       = 5;
    localparam int         BIT_DRQ      = 3;
    localparam int         BIT_ERR      = 0;
    localparam int         BIT_ABORTED_BIT     = 2;
    localparam int         BIT_LBA      = 6;
    localparam logic [7:0] ERR_ABORTED_BIT     = 8'h04;
    localparam logic [7:0] RST_STATUS   = 8'h40;
    localparam logic [7:0] RST_DRVH     = 8'ha0;
    localparam logic [9:0] XLATE_BYTES  = 10'd512;

    // ------------------------------------------------------------------
    // Extended error codes.
    // ------------------------------------------------------------------
    localparam logic [7:0] XE_NONE      = 8'h00;
    localparam logic [7:0] XE_ST_PASS   = 8'h01;
    localparam logic [7:0] XE_WR_ERASE  = 8'h03;
    localparam logic [7:0] XE_ST_FAIL   = 8'h05;
    localparam logic [7:0] XE_MISC      = 8'h09;
    localparam logic [7:0] XE_ID_ERR    = 8'h10;
    localparam logic [7:0] XE_UNC_ECC   = 8'h11;
    localparam logic [7:0] XE_ID_NF     = 8'h14;
    localparam logic [7:0] XE_COR_ECC   = 8'h18;
    localparam logic [7:0] XE_ABORTED   = 8'h1f;
    localparam logic [7:0] XE_BAD_CMD   = 8'h20;
    localparam logic [7:0] XE_BAD_ADDR  = 8'h21;
    localparam logic [7:0] XE_WPROT     = 8'h27;
    localparam logic [7:0] XE_ADDR_OVF  = 8'h2f;
    localparam logic [7:0] XE_ST_LO     = 8'h30;
    localparam logic [7:0] XE_ST_HI     = 8'h34;
    localparam logic [7:0] XE_VOLT_A    = 8'h35;
    localparam logic [7:0] XE_VOLT_B    = 8'h36;
    localparam logic [7:0] XE_ST_37     = 8'h37;
    localparam logic [7:0] XE_ST_3E     = 8'h3e;

    typedef struct packed {
        logic        lba_mode;
        logic [3:0]  head;
        logic [27:0] addr;
    } eest_xaddr_t;

endpackage

// [hw/eest_top.sv]
`timescale 1ns/10ps
`default_nettype none
module eest_top #(
    parameter bit FEATURE_SET = 1'b1
) (
    // Clock and reset.
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // AXI4-Lite write address and data.
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read.
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------------
    // Task-file state.
    // ------------------------------------------------------------------
    logic [7:0] feature_parameter;
    logic [7:0] sector_count;
    logic [7:0] sector_index;
    logic [7:0] cylinder_low_byte;
    logic [7:0] cylinder_high_byte;
    logic [7:0] drive_head_select;
    logic [7:0] error_code;
    logic [7:0] device_status;
    logic [7:0] ext_code;
    logic [7:0] fault_code;
    logic       fault_pending;
    logic       device_fault_flag;
    logic [9:0] xfer_left;
    eest_pkg::eest_xaddr_t xaddr;

    // ------------------------------------------------------------------
    // AXI write path: address and data taken in either order.
    // ------------------------------------------------------------------
    logic       aw_held;
    logic       w_held;
    logic [5:0] aw_addr;
    logic [7:0] w_byte;
    logic       w_lane0;
    wire        aw_take = s_axi_awvalid & s_axi_awready;
    wire        w_take  = s_axi_wvalid & s_axi_wready;
    wire        wr_fire = aw_held & w_held & ~s_axi_bvalid;
    wire        wr_ok   = wr_fire & w_lane0;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_bresp   = 2'b00;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 6'h00;
            w_byte       <= 8'h00;
            w_lane0      <= 1'b0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held  <= 1'b1;
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire wr_feat  = wr_ok & (aw_addr == eest_pkg::ADDR_FEAT);
    wire wr_scnt  = wr_ok & (aw_addr == eest_pkg::ADDR_SCNT);
    wire wr_sidx  = wr_ok & (aw_addr == eest_pkg::ADDR_SIDX);
    wire wr_cyll  = wr_ok & (aw_addr == eest_pkg::ADDR_CYLL);
    wire wr_cylh  = wr_ok & (aw_addr == eest_pkg::ADDR_CYLH);
    wire wr_drvh  = wr_ok & (aw_addr == eest_pkg::ADDR_DRVH);
    wire wr_cmd   = wr_ok & (aw_addr == eest_pkg::ADDR_CMD);
    wire wr_fault = wr_ok & (aw_addr == eest_pkg::ADDR_FAULT);
    wire dev_busy = device_status[eest_pkg::BIT_BSY];
    wire in_pio   = device_status[eest_pkg::BIT_DRQ];

    // ------------------------------------------------------------------
    // Command decode.
    // ------------------------------------------------------------------
    wire is_ext   = FEATURE_SET & (w_byte == eest_pkg::CMD_EXT_ERR); // RULE1
    wire is_xlate = FEATURE_SET & (w_byte == eest_pkg::CMD_XLATE);   // RULE15 RULE16
    wire cmd_go   = wr_cmd & ~dev_busy & ~in_pio;                    // RULE13
    wire xlt_bad  = (xaddr.addr[27:24] != 4'h0) & xaddr.lba_mode;

    // RULE17 RULE18
    assign xaddr.lba_mode = drive_head_select[eest_pkg::BIT_LBA];
    assign xaddr.head     = drive_head_select[3:0];
    assign xaddr.addr     = {(xaddr.lba_mode ? drive_head_select[3:0] : 4'h0),
                             cylinder_high_byte, cylinder_low_byte, sector_index};

    // Legal extended codes only; anything else collapses to miscellaneous.
    function automatic logic [7:0] legal_code(input logic [7:0] c);
        logic ok;
        ok = (c == eest_pkg::XE_NONE)    | (c == eest_pkg::XE_ST_PASS)   // RULE5
           | (c == eest_pkg::XE_WR_ERASE) | (c == eest_pkg::XE_MISC)
           | (c == eest_pkg::XE_ID_ERR)  | (c == eest_pkg::XE_ID_NF)     // RULE6
           | (c == eest_pkg::XE_UNC_ECC) | (c == eest_pkg::XE_COR_ECC)
           | (c == eest_pkg::XE_ABORTED) | (c == eest_pkg::XE_BAD_CMD)   // RULE7
           | (c == eest_pkg::XE_BAD_ADDR) | (c == eest_pkg::XE_WPROT)
           | (c == eest_pkg::XE_ADDR_OVF)
           | (c == eest_pkg::XE_VOLT_A)  | (c == eest_pkg::XE_VOLT_B)    // RULE8
           | (c == eest_pkg::XE_ST_FAIL) | (c == eest_pkg::XE_ST_37)     // RULE9
           | (c == eest_pkg::XE_ST_3E)
           | ((c >= eest_pkg::XE_ST_LO) & (c <= eest_pkg::XE_ST_HI));
        return ok ? c : eest_pkg::XE_MISC;
    endfunction

    // ------------------------------------------------------------------
    // Command execution and status.
    // ------------------------------------------------------------------
    wire [7:0] fault_legal = legal_code(fault_code);
    wire [7:0] next_ext    = fault_pending ? fault_legal : eest_pkg::XE_NONE;
    wire       rd_data;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            feature_parameter  <= 8'h00;
            sector_count       <= 8'h00;
            sector_index       <= 8'h00;
            cylinder_low_byte  <= 8'h00;
            cylinder_high_byte <= 8'h00;
            drive_head_select  <= eest_pkg::RST_DRVH;
            error_code         <= 8'h00;
            device_status      <= eest_pkg::RST_STATUS;
            ext_code           <= eest_pkg::XE_NONE;
            fault_code         <= eest_pkg::XE_NONE;
            fault_pending      <= 1'b0;
            device_fault_flag  <= 1'b0;
            xfer_left          <= 10'd0;
        end else begin
            if (wr_feat) feature_parameter <= w_byte;
            if (wr_scnt) sector_count <= w_byte;
            if (wr_sidx) sector_index <= w_byte;
            if (wr_cyll) cylinder_low_byte <= w_byte;
            if (wr_cylh) cylinder_high_byte <= w_byte;
            if (wr_drvh) drive_head_select <= w_byte;
            if (wr_fault) begin
                fault_code        <= w_byte;
                fault_pending     <= 1'b1;
                device_fault_flag <= w_byte[7];
            end
            if (cmd_go) begin
                device_status[eest_pkg::BIT_BSY] <= 1'b0;
                device_status[eest_pkg::BIT_DEVICE_READY_FLAG] <= 1'b1;            // RULE4 RULE11
                if (is_ext) begin
                    error_code    <= ext_code;                        // RULE3 RULE14
                    ext_code      <= eest_pkg::XE_NONE;               // RULE20
                    device_status[eest_pkg::BIT_ERR] <= 1'b0;         // RULE2 RULE4
                    device_status[eest_pkg::BIT_DF]  <= 1'b0;
                end else if (is_xlate & ~xlt_bad & ~fault_pending) begin
                    error_code    <= 8'h00;
                    ext_code      <= eest_pkg::XE_NONE;
                    xfer_left     <= eest_pkg::XLATE_BYTES;           // RULE19
                    device_status[eest_pkg::BIT_DRQ] <= 1'b1;         // RULE15
                    device_status[eest_pkg::BIT_ERR] <= 1'b0;
                    device_status[eest_pkg::BIT_DF]  <= 1'b0;
                end else begin
                    error_code    <= eest_pkg::ERR_ABORTED_BIT;              // RULE10
                    ext_code      <= (is_xlate & xlt_bad) ? eest_pkg::XE_ADDR_OVF
                                   : (is_xlate & fault_pending) ? next_ext
                                   : eest_pkg::XE_BAD_CMD;            // RULE20
                    device_status[eest_pkg::BIT_ERR] <= 1'b1;         // RULE11
                    device_status[eest_pkg::BIT_DF]  <= device_fault_flag; // RULE12
                end
                if (~is_ext) fault_pending <= 1'b0;
            end else if (rd_data & in_pio) begin
                xfer_left <= xfer_left - 10'd1;
                if (xfer_left == 10'd1) device_status[eest_pkg::BIT_DRQ] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Translate information block, one byte per data-register read.
    // ------------------------------------------------------------------
    wire [9:0] xidx = eest_pkg::XLATE_BYTES - xfer_left;
    logic [7:0] xbyte;
    always_comb begin
        case (xidx)
            10'd0:   xbyte = xaddr.lba_mode ? 8'h00 : cylinder_high_byte;
            10'd1:   xbyte = xaddr.lba_mode ? 8'h00 : cylinder_low_byte;
            10'd2:   xbyte = xaddr.lba_mode ? 8'h00 : {4'h0, xaddr.head};
            10'd3:   xbyte = xaddr.lba_mode ? 8'h00 : sector_index;
            10'd4:   xbyte = xaddr.lba_mode ? xaddr.addr[23:16] : 8'h00;
            10'd5:   xbyte = xaddr.lba_mode ? xaddr.addr[15:8] : 8'h00;
            10'd6:   xbyte = xaddr.lba_mode ? xaddr.addr[7:0] : 8'h00;
            default: xbyte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // AXI read path.
    // ------------------------------------------------------------------
    wire ar_take = s_axi_arvalid & s_axi_arready;
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_data = ar_take & (s_axi_araddr == eest_pkg::ADDR_DATA);
    logic [7:0] rd_mux;
    logic       rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            eest_pkg::ADDR_DATA:  rd_mux = in_pio ? xbyte : 8'h00;
            eest_pkg::ADDR_FEAT:  rd_mux = error_code;
            eest_pkg::ADDR_SCNT:  rd_mux = sector_count;
            eest_pkg::ADDR_SIDX:  rd_mux = sector_index;
            eest_pkg::ADDR_CYLL:  rd_mux = cylinder_low_byte;
            eest_pkg::ADDR_CYLH:  rd_mux = cylinder_high_byte;
            eest_pkg::ADDR_DRVH:  rd_mux = drive_head_select;
            eest_pkg::ADDR_CMD:   rd_mux = device_status;
            eest_pkg::ADDR_CTRL:  rd_mux = ext_code;
            eest_pkg::ADDR_XADDR: rd_mux = {3'h0, xaddr.lba_mode, xaddr.addr[27:24]};
            eest_pkg::ADDR_FAULT: rd_mux = fault_code;
            default: begin
                rd_mux = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_mux};
            s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// [sim/eest_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module eest_checker (
    // Clock and reset.
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    // Write channels.
    input wire logic [5:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Read channels.
    input wire logic [5:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    sequence ar_hit(logic [5:0] a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
    endsequence

    read_answer_a: assert property (ar_take |=> s_axi_rvalid)
        else $error("read request not answered next cycle");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer not held");
    write_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
        else $error("write answer not okay");
    status_ready_a: assert property (ar_hit(eest_pkg::ADDR_CMD) |=> s_axi_rdata[7:6] == 2'b01)
        else $error("status busy or not ready");
    fault_err_a: assert property (ar_hit(eest_pkg::ADDR_CMD) |=> !s_axi_rdata[5] || s_axi_rdata[0])
        else $error("fault flag outside an error outcome");
    byte_wide_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data wider than a byte");
    unmapped_read_a: assert property (ar_take and s_axi_araddr > 6'h28 |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    pend_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
endmodule

bind eest_top eest_checker u_chk (.*);
`default_nettype wire

// [sim/eest_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module eest_host_model (
    // Clock.
    input  wire logic        clk_sys_i,
    // Requests towards the device.
    output var logic [5:0]   s_axi_awaddr,
    output var logic         s_axi_awvalid,
    output var logic [31:0]  s_axi_wdata,
    output var logic [3:0]   s_axi_wstrb,
    output var logic         s_axi_wvalid,
    output var logic         s_axi_bready,
    output var logic [5:0]   s_axi_araddr,
    output var logic         s_axi_arvalid,
    output var logic         s_axi_rready,
    // Answers from the device.
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wready,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    // A nonzero stall keeps the response ready low for that many edges.
    task automatic wr(input logic [5:0] a, input logic [7:0] d,
                      input logic [3:0] be = 4'h1, input int stall = 0);
        int n;
        n = stall;
        @(posedge clk_sys_i);
        s_axi_awaddr <= a;
        s_axi_wdata  <= {24'h0, d};
        s_axi_wstrb  <= be;
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        s_axi_bready <= (n == 0);
        forever begin
            @(posedge clk_sys_i);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~{24'h0, d};
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bready <= 1'b0;
                break;
            end
            if (n > 0) n--;
            s_axi_bready <= (n == 0);
        end
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r,
                      input int stall = 0);
        int n;
        n = stall;
        @(posedge clk_sys_i);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= (n == 0);
        forever begin
            @(posedge clk_sys_i);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr  <= ~a;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
            if (n > 0) n--;
            s_axi_rready <= (n == 0);
        end
    endtask

    // A command is only written while the device reports itself ready.
    task automatic cmd(input logic [7:0] c);
        logic [31:0] s;
        logic [1:0]  r;
        rd(eest_pkg::ADDR_CMD, s, r);
        if (s[eest_pkg::BIT_DEVICE_READY_FLAG]) wr(eest_pkg::ADDR_CMD, c);
    endtask
endmodule
`default_nettype wire

// [sim/ext_error_and_sector_translate_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module ext_error_and_sector_translate_tb_top;
    logic        clk_sys_i, rst_i;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          n_errors;
    int          checks_done;

    eest_top        u_dut  (.*);
    eest_host_model u_host (.*);

    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rdchk(input string what, input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        u_host.rd(a, d, r);
        chk(what, d, exp);
    endtask

    task automatic close_out;
        if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic t_reset;
        rdchk("status", eest_pkg::ADDR_CMD, 32'h40);
        rdchk("error", eest_pkg::ADDR_FEAT, 32'h0);
        rdchk("drive head", eest_pkg::ADDR_DRVH, 32'ha0);
        u_host.wr(eest_pkg::ADDR_SCNT, 8'h5a);
        rdchk("count", eest_pkg::ADDR_SCNT, 32'h5a);
        u_host.wr(eest_pkg::ADDR_SCNT, 8'ha5, 4'h0, 3);
        rdchk("count no lane", eest_pkg::ADDR_SCNT, 32'h5a);
    endtask

    task automatic t_midreset;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rdchk("status", eest_pkg::ADDR_CMD, 32'h40);
        rdchk("pending code", eest_pkg::ADDR_CTRL, 32'h0);
    endtask

    task automatic t_abort;
        u_host.cmd(8'h50);
        rdchk("status", eest_pkg::ADDR_CMD, 32'h41);
        rdchk("error", eest_pkg::ADDR_FEAT, 32'h04);
        rdchk("pending code", eest_pkg::ADDR_CTRL, 32'h20);
        u_host.cmd(8'h03);
        rdchk("ext code", eest_pkg::ADDR_FEAT, 32'h20);
        rdchk("status", eest_pkg::ADDR_CMD, 32'h40);
        u_host.cmd(8'h03);
        rdchk("ext code", eest_pkg::ADDR_FEAT, 32'h00);
        u_host.wr(eest_pkg::ADDR_FAULT, 8'h80);
        rdchk("fault", eest_pkg::ADDR_FAULT, 32'h80);
        u_host.cmd(8'h50);
        rdchk("status", eest_pkg::ADDR_CMD, 32'h61);
    endtask

    task automatic t_codes;
        logic [7:0] codes [20] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h10, 8'h11, 8'h14, 8'h18,
            8'h1f, 8'h20, 8'h21, 8'h27, 8'h2f, 8'h30, 8'h34, 8'h35, 8'h36, 8'h37, 8'h3e, 8'h02};
        foreach (codes[i]) begin
            u_host.wr(eest_pkg::ADDR_FAULT, codes[i]);
            u_host.cmd(8'h87);
            rdchk("status", eest_pkg::ADDR_CMD, 32'h41);
            u_host.cmd(8'h03);
            rdchk("ext code", eest_pkg::ADDR_FEAT, (codes[i] == 8'h02) ? 32'h09 : codes[i]);
        end
    endtask

    task automatic t_xlate(input logic linear_block_addressing, input logic [3:0] nib, input logic [7:0] s,
                           input logic [7:0] cl, input logic [7:0] ch);
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  e;
        u_host.wr(eest_pkg::ADDR_SIDX, s);
        u_host.wr(eest_pkg::ADDR_CYLL, cl);
        u_host.wr(eest_pkg::ADDR_CYLH, ch);
        u_host.wr(eest_pkg::ADDR_DRVH, {1'b1, linear_block_addressing, 2'b10, nib});
        u_host.cmd(8'h87);
        if (linear_block_addressing && nib != 4'h0) begin
            u_host.cmd(8'h03);
            rdchk("ext code", eest_pkg::ADDR_FEAT, 32'h2f);
            return;
        end
        rdchk("status", eest_pkg::ADDR_CMD, 32'h48);
        rdchk("decoded", eest_pkg::ADDR_XADDR, {27'h0, linear_block_addressing, (linear_block_addressing ? nib : 4'h0)});
        u_host.cmd(8'h50);
        rdchk("status in pio", eest_pkg::ADDR_CMD, 32'h48);
        for (int i = 0; i < 512; i++) begin
            u_host.rd(eest_pkg::ADDR_DATA, d, r);
            e = 8'h00;
            if (linear_block_addressing) e = (i == 4) ? ch : (i == 5) ? cl : (i == 6) ? s : 8'h00;
            else e = (i == 0) ? ch : (i == 1) ? cl : (i == 2) ? {4'h0, nib} : (i == 3) ? s : 8'h00;
            chk("table byte", d, {24'h0, e});
        end
        rdchk("status", eest_pkg::ADDR_CMD, 32'h40);
    endtask

    task automatic t_unmapped;
        logic [31:0] d;
        logic [1:0]  r;
        u_host.wr(6'h3c, 8'h55, 4'h1, 3);
        u_host.rd(6'h3c, d, r, 3);
        chk("unmapped resp", {30'h0, r}, 32'h2);
        chk("unmapped data", d, 32'h0);
    endtask

    initial begin
        #100000;
        n_errors++;
        close_out();
    end

    initial begin
        n_errors = 0;
        checks_done = 0;
        rst_i = 1'b1;
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset();
        t_abort();
        t_midreset();
        t_codes();
        t_xlate(1'b1, 4'h0, 8'h3c, 8'h5a, 8'hc3);
        t_xlate(1'b0, 4'h5, 8'h11, 8'h22, 8'h33);
        t_xlate(1'b1, 4'h3, 8'h01, 8'h02, 8'h03);
        t_unmapped();
        close_out();
    end
endmodule
`default_nettype wire
